// ===== src/lifd_pkg.sv
// Package: constants, function codes and register map for the input decoder
// Assumes: included ahead of every design file that imports it
package lifd_pkg;

	// ----------------------------------------
	// Terminal functions
	// ----------------------------------------
	localparam int FN_W     = 5;
	localparam int FN_COUNT = 18;

	typedef enum logic [FN_W-1:0] {
		FN_NONE       = 5'h00,
		FN_DRV_ENABLE = 5'h01,
		FN_RUN        = 5'h02,
		FN_RUN_DOWN   = 5'h03,
		FN_RUN_UP     = 5'h04,
		FN_OSPD_TEST  = 5'h05,
		FN_PRETRQ     = 5'h06,
		FN_SCURVE0    = 5'h07,
		FN_SCURVE1    = 5'h08,
		FN_STEP0      = 5'h09,
		FN_STEP1      = 5'h0A,
		FN_STEP2      = 5'h0B,
		FN_STEP3      = 5'h0C,
		FN_TRQ_RAMP   = 5'h0D,
		FN_SIGN_INV   = 5'h0E,
		FN_BRK_HOLD   = 5'h0F,
		FN_BRK_PICK   = 5'h10,
		FN_SER_INSP   = 5'h11
	} fn_e;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int          ADDR_W      = 8;
	localparam int          DATA_W      = 32;
	localparam int          MULT_W      = 8;
	localparam logic [7:0]  OFS_SEL     = 8'h00;
	localparam logic [7:0]  OFS_CFG     = 8'h40;
	localparam logic [7:0]  OFS_MULT    = 8'h44;
	localparam logic [7:0]  OFS_STATUS  = 8'h48;
	localparam logic [7:0]  OFS_PRETRQ  = 8'h4C;
	localparam logic [2:0]  CFG_RESET   = 3'h0;
	localparam logic [7:0]  MULT_RESET  = 8'h00;
	localparam int          CFG_DIRC    = 0;
	localparam int          CFG_OSPD_EXT = 1;
	localparam int          CFG_SER2    = 2;

endpackage

// ===== src/term_if.sv
// Interface: synchronised terminal levels and their rising-edge pulses
// Assumes: one producer (synchroniser) and one consumer (decoder)
`timescale 1ns/1ps
interface term_if #(parameter int N = 9);
	logic [N-1:0] level;
	logic [N-1:0] rise;
	modport src (output level, output rise);
	modport dst (input level, input rise);
endinterface

// ===== src/term_sync.sv
// Module: two-flop synchroniser and rising-edge detector per terminal
// Assumes: raw terminal levels, one clock, clock enable freezes state
`timescale 1ns/1ps
module term_sync #(
	parameter int N = 9
) (
	// Clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         ce,
	// Terminals
	input  wire logic [N-1:0] raw,
	term_if.src               tio
);

	logic [N-1:0] s1_q;
	logic [N-1:0] s2_q;
	logic [N-1:0] prev_q;

	// ----------------------------------------
	// Synchroniser and edge detector
	// ----------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			s1_q   <= '0;
			s2_q   <= '0;
			prev_q <= '0;
		end else if (ce) begin
			s1_q   <= raw;    // see (R22)
			s2_q   <= s1_q;
			prev_q <= s2_q;
		end
	end

	assign tio.level = s2_q;
	assign tio.rise  = s2_q & ~prev_q & {N{ce}};  // see (R23)

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_rise_single;
		@(posedge clk) disable iff (rst)
		ce && (tio.rise != '0) |=> ((tio.rise & $past(tio.rise)) == '0);
	endproperty
	a_rise_single: assert property (p_rise_single) else $error("edge pulse longer than one cycle"); // see (R23)

	property p_rise_cause;
		@(posedge clk) disable iff (rst)
		(tio.rise != '0) |-> ((tio.rise & ~$past(s1_q, 1)) == '0);
	endproperty
	a_rise_cause: assert property (p_rise_cause) else $error("edge without synchronised level"); // see (R22)

endmodule

// ===== src/logic_input_function_decoder.sv
// Module: decodes assignable contact inputs into run, speed and brake commands
// Assumes: Avalon-MM master with waitrequest, inputs synchronous to CORE_CLK
`timescale 1ns/1ps

// Contract
// (R01) A terminal set to no function has no effect on anything.
// (R02) Plain run starts drive only while drive permit is asserted.
// (R03) Permit plus run-down starts drive, negative sign, unless direction confirm.
// (R04) Permit plus run-up starts drive with positive speed sign.
// (R05) Run-up and run-down together: no run request recognised.
// (R06) Direction confirm: run-down keeps sign, confirms analog polarity, starts drive.
// (R07) Direction confirm: run-up also confirms analog polarity while starting drive.
// (R08) Overspeed-test input acts only when source selects the terminal strip.
// (R09) Armed overspeed test scales speed command by multiplier for next run.
// (R10) Run drop after overspeed-test run returns to normal; rearm needed.
// (R11) During overspeed-test run fault threshold is raised by the multiplier.
// (R12) Test armed only on rising edge; held-true input ignored afterwards.
// (R13) Pre-torque latch rising edge captures and holds pre-torque command.
// (R14) Two S-curve inputs form bit 0 and bit 1 of profile code.
// (R15) Four step inputs form one 4-bit multi-step speed code.
// (R16) Torque ramp-down input requests ramping torque to zero.
// (R17) Speed-sign input inverts speed sign when true, none when false.
// (R18) Brake-hold input reports mechanical brake engaged in hold mode.
// (R19) Brake-lift input reports brake picked exactly when asserted.
// (R20) Serial inspection enable honoured only in second serial mode.
// (R21) Permit needed for any run; permit alone never starts a run.
// (R22) Each terminal routed to its selected function after synchronisation.
// (R23) Edge functions compare synced level with previous; one-cycle pulse.
module logic_input_function_decoder
	import lifd_pkg::*;
#(
	parameter int N       = 9,
	parameter int PRETQ_W = 16
) (
	// Clock and reset
	input  wire logic                CORE_CLK,
	input  wire logic                SYS_RST,
	input  wire logic                CLK_EN,
	// Contact terminals
	input  wire logic [N-1:0]        TERM_IN,
	// Register bus
	input  wire logic [ADDR_W-1:0]   AVS_ADDRESS,
	input  wire logic                AVS_READ,
	input  wire logic                AVS_WRITE,
	input  wire logic [DATA_W-1:0]   AVS_WRITEDATA,
	output logic      [DATA_W-1:0]   AVS_READDATA,
	output logic                     AVS_WAITREQUEST,
	// Drive side inputs
	input  wire logic [PRETQ_W-1:0]  PRETRQ_CMD,
	input  wire logic                ANALOG_CMD_NEG,
	// Decoded commands
	output logic                     RUN_CMD,
	output logic                     SPEED_NEG,
	output logic                     POLARITY_OK,
	output logic                     OSPD_SCALE_EN,
	output logic                     OSPD_FAULT_RAISE,
	output logic      [MULT_W-1:0]   OSPD_MULT,
	output logic      [PRETQ_W-1:0]  PRETRQ_HELD,
	output logic      [1:0]          SCURVE_SEL,
	output logic      [3:0]          STEP_SEL,
	output logic                     TRQ_RAMP_DOWN,
	output logic                     BRAKE_HOLD,
	output logic                     BRAKE_PICK,
	output logic                     INSP_RUN
);

	// ----------------------------------------
	// Synchronised terminals
	// ----------------------------------------
	term_if #(.N(N)) tio ();

	term_sync #(.N(N)) u_sync (
		.clk (CORE_CLK),
		.rst (SYS_RST),
		.ce  (CLK_EN),
		.raw (TERM_IN),
		.tio (tio)
	);

	// ----------------------------------------
	// Function routing
	// ----------------------------------------
	logic [FN_W-1:0]     sel_q [N];
	logic [FN_COUNT-1:0] fn_lvl;
	logic [FN_COUNT-1:0] fn_rise;

	for (genvar f = 0; f < FN_COUNT; f++) begin : g_fn
		logic [N-1:0] hit;
		for (genvar t = 0; t < N; t++) begin : g_term
			assign hit[t] = (sel_q[t] == FN_W'(f)) && (FN_W'(f) != FN_NONE);  // see (R01)
		end
		assign fn_lvl[f]  = |(hit & tio.level);  // see (R22)
		assign fn_rise[f] = |(hit & tio.rise);
	end

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [2:0]        cfg_q;
	logic [MULT_W-1:0] mult_q;
	wire               cfg_dirc     = cfg_q[CFG_DIRC];
	wire               cfg_ospd_ext = cfg_q[CFG_OSPD_EXT];
	wire               cfg_ser2     = cfg_q[CFG_SER2];

	// ----------------------------------------
	// Run and direction decode
	// ----------------------------------------
	wire en        = fn_lvl[FN_DRV_ENABLE];
	wire up        = fn_lvl[FN_RUN_UP];
	wire down      = fn_lvl[FN_RUN_DOWN];
	wire sign_inv  = fn_lvl[FN_SIGN_INV];
	wire dir_clash = up & down;                                        // see (R05)
	wire run_d     = en & ~dir_clash & (fn_lvl[FN_RUN] | up | down);   // see (R02) see (R21)
	wire down_neg  = down & ~dir_clash & ~cfg_dirc;                    // see (R03) see (R06)
	wire neg_d     = down_neg ^ sign_inv;                              // see (R04) see (R17)
	wire pol_up    = up & ~down & ~ANALOG_CMD_NEG;                     // see (R07)
	wire pol_down  = down & ~up & ANALOG_CMD_NEG;                      // see (R06)
	wire pol_d     = cfg_dirc & run_d & (pol_up | pol_down);

	// ----------------------------------------
	// Overspeed test sequencing
	// ----------------------------------------
	logic run_q;
	logic armed_q;
	logic active_q;
	wire  arm_set   = fn_rise[FN_OSPD_TEST] & cfg_ospd_ext & ~active_q;  // see (R08) see (R12)
	wire  run_start = run_d & ~run_q;
	wire  run_stop  = ~run_d & run_q;
	wire  test_end  = active_q & run_stop;

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			armed_q  <= 1'b0;
			active_q <= 1'b0;
		end else if (CLK_EN) begin
			if (test_end)
				armed_q <= 1'b0;                // see (R10)
			else if (arm_set)
				armed_q <= 1'b1;                // see (R12)
			if (test_end)
				active_q <= 1'b0;               // see (R10)
			else if (run_start && armed_q)
				active_q <= 1'b1;               // see (R09)
		end
	end

	// ----------------------------------------
	// Decoded command outputs
	// ----------------------------------------
	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			run_q         <= 1'b0;
			SPEED_NEG     <= 1'b0;
			POLARITY_OK   <= 1'b0;
			SCURVE_SEL    <= 2'h0;
			STEP_SEL      <= 4'h0;
			TRQ_RAMP_DOWN <= 1'b0;
			BRAKE_HOLD    <= 1'b0;
			BRAKE_PICK    <= 1'b0;
			INSP_RUN      <= 1'b0;
			PRETRQ_HELD   <= '0;
		end else if (CLK_EN) begin
			run_q         <= run_d;
			SPEED_NEG     <= neg_d;
			POLARITY_OK   <= pol_d;
			SCURVE_SEL    <= {fn_lvl[FN_SCURVE1], fn_lvl[FN_SCURVE0]};  // see (R14)
			STEP_SEL      <= {fn_lvl[FN_STEP3], fn_lvl[FN_STEP2],
				fn_lvl[FN_STEP1], fn_lvl[FN_STEP0]};                // see (R15)
			TRQ_RAMP_DOWN <= fn_lvl[FN_TRQ_RAMP];                       // see (R16)
			BRAKE_HOLD    <= fn_lvl[FN_BRK_HOLD];                       // see (R18)
			BRAKE_PICK    <= fn_lvl[FN_BRK_PICK];                       // see (R19)
			INSP_RUN      <= fn_lvl[FN_SER_INSP] & cfg_ser2;            // see (R20)
			if (fn_rise[FN_PRETRQ])
				PRETRQ_HELD <= PRETRQ_CMD;                              // see (R13)
		end
	end

	assign RUN_CMD          = run_q;
	assign OSPD_SCALE_EN    = active_q;   // see (R09)
	assign OSPD_FAULT_RAISE = active_q;   // see (R11)
	assign OSPD_MULT        = mult_q;

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	logic              ack_q;
	logic [DATA_W-1:0] rd_d;
	wire               req      = AVS_READ | AVS_WRITE;
	wire               wr_fire  = AVS_WRITE & ack_q;
	wire  [3:0]        sel_idx  = AVS_ADDRESS[5:2];
	wire               is_sel   = (AVS_ADDRESS < OFS_CFG) && (32'(sel_idx) < N);
	wire  [DATA_W-1:0] status_w = {21'h0, armed_q, active_q, INSP_RUN, BRAKE_PICK,
		BRAKE_HOLD, TRQ_RAMP_DOWN, POLARITY_OK, SPEED_NEG, run_q, en, dir_clash};

	assign AVS_WAITREQUEST = req & ~ack_q;

	always_comb begin
		rd_d = '0;
		if (is_sel)
			rd_d = DATA_W'(sel_q[sel_idx]);
		else if (AVS_ADDRESS == OFS_CFG)
			rd_d = DATA_W'(cfg_q);
		else if (AVS_ADDRESS == OFS_MULT)
			rd_d = DATA_W'(mult_q);
		else if (AVS_ADDRESS == OFS_STATUS)
			rd_d = status_w;
		else if (AVS_ADDRESS == OFS_PRETRQ)
			rd_d = DATA_W'(PRETRQ_HELD);
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			ack_q        <= 1'b0;
			AVS_READDATA <= '0;
		end else if (CLK_EN) begin
			ack_q <= req & ~ack_q;
			if (AVS_READ && !ack_q)
				AVS_READDATA <= rd_d;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (SYS_RST) begin
			cfg_q  <= CFG_RESET;
			mult_q <= MULT_RESET;
			for (int t = 0; t < N; t++)
				sel_q[t] <= FN_NONE;
		end else if (CLK_EN && wr_fire) begin
			if (is_sel)
				sel_q[sel_idx] <= AVS_WRITEDATA[FN_W-1:0];  // see (R22)
			else if (AVS_ADDRESS == OFS_CFG)
				cfg_q <= AVS_WRITEDATA[2:0];
			else if (AVS_ADDRESS == OFS_MULT)
				mult_q <= AVS_WRITEDATA[MULT_W-1:0];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	sequence s_armed_start;
		CLK_EN && armed_q && run_d && !run_q;
	endsequence

	sequence s_test_end;
		CLK_EN && active_q && !run_d;
	endsequence

	property p_no_clash_run;
		CLK_EN && up && down |=> !RUN_CMD;
	endproperty
	a_no_clash_run: assert property (p_no_clash_run) else $error("run with both directions"); // see (R05)

	property p_permit;
		CLK_EN && !en |=> !RUN_CMD;
	endproperty
	a_permit: assert property (p_permit) else $error("run without permit"); // see (R02)

	property p_permit_alone;
		CLK_EN && en && !fn_lvl[FN_RUN] && !up && !down |=> !RUN_CMD;
	endproperty
	a_permit_alone: assert property (p_permit_alone) else $error("permit alone started run"); // see (R21)

	property p_down_neg;
		CLK_EN && en && down && !up && !cfg_dirc && !sign_inv |=> RUN_CMD && SPEED_NEG;
	endproperty
	a_down_neg: assert property (p_down_neg) else $error("run down not negative"); // see (R03)

	property p_up_pos;
		CLK_EN && en && up && !down && !sign_inv |=> RUN_CMD && !SPEED_NEG;
	endproperty
	a_up_pos: assert property (p_up_pos) else $error("run up not positive"); // see (R04)

	property p_dirc_keep;
		CLK_EN && cfg_dirc && down && !up && !sign_inv |=> !SPEED_NEG;
	endproperty
	a_dirc_keep: assert property (p_dirc_keep) else $error("confirm mode changed sign"); // see (R06)

	property p_dirc_confirm;
		CLK_EN && cfg_dirc && en && up && !down && !ANALOG_CMD_NEG |=> POLARITY_OK && RUN_CMD;
	endproperty
	a_dirc_confirm: assert property (p_dirc_confirm) else $error("up polarity not confirmed"); // see (R07)

	property p_ospd_src;
		CLK_EN && !cfg_ospd_ext && !armed_q |=> !armed_q;
	endproperty
	a_ospd_src: assert property (p_ospd_src) else $error("test armed from wrong source"); // see (R08)

	property p_ospd_start;
		s_armed_start |=> OSPD_SCALE_EN && OSPD_FAULT_RAISE && RUN_CMD;
	endproperty
	a_ospd_start: assert property (p_ospd_start) else $error("armed run not scaled"); // see (R09)

	property p_ospd_end;
		s_test_end |=> !OSPD_SCALE_EN && !armed_q;
	endproperty
	a_ospd_end: assert property (p_ospd_end) else $error("test not ended on run drop"); // see (R10)

	property p_ospd_only_run;
		OSPD_FAULT_RAISE |-> RUN_CMD;
	endproperty
	a_ospd_only_run: assert property (p_ospd_only_run) else $error("threshold raised outside run"); // see (R11)

	property p_pretrq;
		CLK_EN && fn_rise[FN_PRETRQ] |=> PRETRQ_HELD == $past(PRETRQ_CMD);
	endproperty
	a_pretrq: assert property (p_pretrq) else $error("pre-torque not latched"); // see (R13)

	property p_step;
		CLK_EN |=> STEP_SEL == {$past(fn_lvl[FN_STEP3]), $past(fn_lvl[FN_STEP2]),
			$past(fn_lvl[FN_STEP1]), $past(fn_lvl[FN_STEP0])};
	endproperty
	a_step: assert property (p_step) else $error("step code mismatch"); // see (R15)

	property p_insp;
		CLK_EN && !cfg_ser2 |=> !INSP_RUN;
	endproperty
	a_insp: assert property (p_insp) else $error("inspection outside serial mode 2"); // see (R20)

	property p_arm_edge;
		CLK_EN && !armed_q && !fn_rise[FN_OSPD_TEST] |=> !armed_q;
	endproperty
	a_arm_edge: assert property (p_arm_edge) else $error("test armed without rising edge"); // see (R12)

	property p_scurve;
		CLK_EN |=> SCURVE_SEL == {$past(fn_lvl[FN_SCURVE1]), $past(fn_lvl[FN_SCURVE0])};
	endproperty
	a_scurve: assert property (p_scurve) else $error("profile code mismatch"); // see (R14)

	property p_trq_ramp;
		CLK_EN |=> TRQ_RAMP_DOWN == $past(fn_lvl[FN_TRQ_RAMP]);
	endproperty
	a_trq_ramp: assert property (p_trq_ramp) else $error("ramp request mismatch"); // see (R16)

	property p_sign_inv;
		CLK_EN && en && down && !up && !cfg_dirc && sign_inv |=> RUN_CMD && !SPEED_NEG;
	endproperty
	a_sign_inv: assert property (p_sign_inv) else $error("run down sign not inverted"); // see (R17)

	property p_brake;
		CLK_EN |=> BRAKE_HOLD == $past(fn_lvl[FN_BRK_HOLD]) && BRAKE_PICK == $past(fn_lvl[FN_BRK_PICK]);
	endproperty
	a_brake: assert property (p_brake) else $error("brake confirmation mismatch"); // see (R18) (R19)

endmodule

// ===== dv/car_ctrl.sv
// Model: car controller driving the contact terminals
// Assumes: wanted levels set by the bench after a clock edge
`timescale 1ns/1ps
module car_ctrl #(
	parameter int N = 9
) (
	// Clock
	input  wire logic         clk,
	// Wanted and driven levels
	input  wire logic [N-1:0] want,
	output logic      [N-1:0] term
);
	// -----------------------------
	// Contact levels
	// -----------------------------
	// All levels move on one edge, step bits together
	always_ff @(posedge clk) begin
		term <= want;
	end
endmodule

// ===== dv/logic_input_function_decoder_tb.sv
// Bench: decoder fed by a car controller model and an Avalon master
// Assumes: clock enable high except in the freeze step, three-edge terminal latency
`timescale 1ns/1ps
module logic_input_function_decoder_tb;
	import lifd_pkg::*;
	// -----------------------------
	// Signals
	// -----------------------------
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ce = 1'b1;
	logic [7:0]  addr = 8'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic        wait_req;
	logic [15:0] ptq = 16'h0;
	logic        aneg = 1'b0;
	logic [8:0]  want = 9'h000;
	logic [8:0]  term;
	logic        run, neg, polok, oscale, ofault, ramp, hold, pick, insp;
	logic [7:0]  omult;
	logic [15:0] held;
	logic [1:0]  scurve;
	logic [3:0]  step;
	logic [10:0] lvl;
	int          failures = 0;
	int          tests_run = 0;
	int          k, c;
	localparam fn_e        MAP [7]  = '{FN_DRV_ENABLE, FN_RUN, FN_RUN_DOWN, FN_RUN_UP,
		FN_SIGN_INV, FN_OSPD_TEST, FN_PRETRQ};
	localparam logic [4:0] LC [11]  = '{5'h00, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
		5'h0D, 5'h0F, 5'h10, 5'h11};
	// Fields: direction confirm, analog negative, terminals 4..0, run/neg/polarity ok
	localparam logic [9:0] RT [11]  = '{10'b0_0_00001_000, 10'b0_0_00010_000,
		10'b0_0_00011_100, 10'b0_0_00101_110, 10'b0_0_01001_100, 10'b0_0_01101_000,
		10'b0_0_11001_110, 10'b0_0_10101_100, 10'b1_1_00101_101, 10'b1_0_01001_101,
		10'b1_1_01001_100};

	always #25 clk = ~clk;

	car_ctrl #(.N(9)) model (.clk(clk), .want(want), .term(term));

	assign lvl = {run, scurve, step, ramp, hold, pick, insp};

	logic_input_function_decoder #(.N(9), .PRETQ_W(16)) dut (
		.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(ce), .TERM_IN(term),
		.AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
		.AVS_READDATA(rdata), .AVS_WAITREQUEST(wait_req), .PRETRQ_CMD(ptq),
		.ANALOG_CMD_NEG(aneg), .RUN_CMD(run), .SPEED_NEG(neg), .POLARITY_OK(polok),
		.OSPD_SCALE_EN(oscale), .OSPD_FAULT_RAISE(ofault), .OSPD_MULT(omult),
		.PRETRQ_HELD(held), .SCURVE_SEL(scurve), .STEP_SEL(step),
		.TRQ_RAMP_DOWN(ramp), .BRAKE_HOLD(hold), .BRAKE_PICK(pick), .INSP_RUN(insp));

	// -----------------------------
	// Tasks
	// -----------------------------
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= w;
		rd <= !w;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (wait_req === 1'b0) break;
		end
		q = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		if (i == 50) begin
			failures++;
			final_report();
		end
	endtask

	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask

	task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(n, e, q);
	endtask

	task automatic lv(input logic [8:0] v, input logic an, input logic [15:0] p);
		@(posedge clk);
		want <= v;
		aneg <= an;
		ptq <= p;
		repeat (5) @(posedge clk);
	endtask

	function automatic logic [31:0] lexp(input logic [4:0] f, input logic s);
		case (f)
			5'h07: lexp = 32'h100;
			5'h08: lexp = 32'h200;
			5'h09: lexp = 32'h010;
			5'h0A: lexp = 32'h020;
			5'h0B: lexp = 32'h040;
			5'h0C: lexp = 32'h080;
			5'h0D: lexp = 32'h008;
			5'h0F: lexp = 32'h004;
			5'h10: lexp = 32'h002;
			5'h11: lexp = {31'h0, s};
			default: lexp = 32'h0;
		endcase
	endfunction

	// -----------------------------
	// Sequence
	// -----------------------------
	initial begin
		repeat (100000) @(posedge clk);
		failures++;
		final_report();
	end

	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		chk("reset", 32'h0, 32'({run, neg, polok, oscale, ofault, omult, held}));
		rchk("map", OFS_SEL, 32'h0);
		wreg(8'h80, 32'hFFFFFFFF);
		rchk("unmapped", 8'h80, 32'h0);
		for (k = 0; k < 7; k++) begin
			wreg(8'(4 * k), {27'h0, MAP[k]});
			rchk("map", 8'(4 * k), {27'h0, MAP[k]});
		end
		$display("test registers finished");
		for (k = 0; k < 11; k++) begin
			wreg(OFS_CFG, {31'h0, RT[k][9]});
			lv({4'h0, RT[k][7:3]}, RT[k][8], 16'h0);
			chk("run", 32'(RT[k][2:0]), 32'({run, neg, polok}));
		end
		$display("test run finished");
		wreg(OFS_MULT, 32'h5A);
		rchk("mult", OFS_MULT, 32'h5A);
		chk("omult", 32'h5A, 32'(omult));
		wreg(OFS_CFG, 32'h0);
		lv(9'h020, 1'b0, 16'h0);
		lv(9'h029, 1'b0, 16'h0);
		chk("ospd", 32'h0, 32'({oscale, ofault}));
		lv(9'h000, 1'b0, 16'h0);
		wreg(OFS_CFG, 32'h2);
		lv(9'h020, 1'b0, 16'h0);
		rchk("status", OFS_STATUS, 32'h400);
		lv(9'h029, 1'b0, 16'h0);
		chk("ospd", 32'h3, 32'({oscale, ofault}));
		rchk("status", OFS_STATUS, 32'h606);
		lv(9'h020, 1'b0, 16'h0);
		chk("ospd", 32'h0, 32'({oscale, ofault}));
		lv(9'h029, 1'b0, 16'h0);
		chk("ospd", 32'h0, 32'({oscale, ofault}));
		lv(9'h000, 1'b0, 16'h0);
		lv(9'h020, 1'b0, 16'h0);
		lv(9'h029, 1'b0, 16'h0);
		chk("ospd", 32'h3, 32'({oscale, ofault}));
		lv(9'h000, 1'b0, 16'h0);
		$display("test overspeed finished");
		lv(9'h040, 1'b0, 16'h1234);
		lv(9'h040, 1'b0, 16'hBEEF);
		chk("held", 32'h1234, 32'(held));
		rchk("held", OFS_PRETRQ, 32'h1234);
		lv(9'h000, 1'b0, 16'hBEEF);
		lv(9'h040, 1'b0, 16'hBEEF);
		chk("held", 32'hBEEF, 32'(held));
		$display("test pretorque finished");
		for (c = 0; c < 2; c++) begin
			wreg(OFS_CFG, 32'(c * 4));
			for (k = 0; k < 11; k++) begin
				wreg(8'h20, {27'h0, LC[k]});
				lv(9'h100, 1'b0, 16'h0);
				chk("level", lexp(LC[k], c[0]), 32'(lvl));
			end
		end
		wreg(8'h20, 32'h0);
		for (k = 0; k < 6; k++) begin
			wreg(8'(4 * k), 32'(k < 4 ? 9 + k : 3 + k));
		end
		lv(9'h02A, 1'b0, 16'h0);
		chk("select", 32'h2A, 32'({scurve, step}));
		lv(9'h015, 1'b0, 16'h0);
		chk("select", 32'h15, 32'({scurve, step}));
		@(posedge clk);
		ce <= 1'b0;
		lv(9'h02A, 1'b0, 16'h0);
		chk("frozen", 32'h15, 32'({scurve, step}));
		@(posedge clk);
		ce <= 1'b1;
		repeat (5) @(posedge clk);
		chk("select", 32'h2A, 32'({scurve, step}));
		$display("test levels finished");
		final_report();
	end
endmodule
